// *** rtl/dacc_core.sv ***
// Accumulator datapath: 40-bit add/sub, overflow and clip flags, clip modes,
// write-back with rounding, data write clip and barrel shifter.
// Assumes the instruction decoder presents one operation per cycle.
// How it works
// RULE_01: 40-bit adder, zero input, carry or borrow
// RULE_02: Guard flag when bits 32..39 differ
// RULE_03: Guard flags recomputed on each adder pass
// RULE_04: Guard flag plus its enable raises trap
// RULE_05: Clip flags sticky, cleared only by software
// RULE_06: Clip off: flag records bit-39 wrap, traps
// RULE_07: Combined guard bit and combined clip bit
// RULE_08: Clip decision from result, flags, config bits
// RULE_09: 40-bit mode clips to 9.31 limits
// RULE_10: 32-bit mode clips to 1.31 limits
// RULE_11: 32-bit mode never sets guard flags
// RULE_12: Wrap mode: no clip, flag, optional trap
// RULE_13: Multiply-class writes rounded non-target high word
// RULE_14: Write-back direct or indirect with +2
// RULE_15: Stores round by mode or truncate
// RULE_16: Conventional round adds bit 15
// RULE_17: Convergent round ties use bit 16
// RULE_18: Plain store truncates, rounded variant rounds
// RULE_19: Store clip to 0x7FFF or 0x8000
// RULE_20: Clip off passes; accumulator never changed
// RULE_21: Signed shift amount, one cycle
// RULE_22: Shifter sources and X bus placement
// RULE_23: Each accumulator has own clip enable
// RULE_24: Only target accumulator flags update
module dacc_core
	import dacc_pkg::*;
(
	input wire logic mclk,                       // Core clock, 20 MHz
	input wire logic resetn,                     // Asynchronous reset, active low
	input wire logic [15:0] core_config_register, // Clip enables and clip width
	input wire logic first_guard_trap_enable,    // Trap on first guard overflow
	input wire logic second_guard_trap_enable,   // Trap on second guard overflow
	input wire logic wrap_trap_enable,           // Trap on bit-39 wrap
	input wire logic round_mode_select,          // 1 convergent rounding
	input wire logic store_clip_enable,          // Clip words written to data
	input wire logic add_valid,                  // Adder pass this cycle
	input wire logic target_sel,                 // 0 first, 1 second accumulator
	input wire logic subtract,                   // Subtract (complement, borrow)
	input wire logic zero_acc_in,                // Force zero on accumulator side
	input wire logic carry_in,                   // Carry (add) or borrow_n (sub)
	input wire logic [39:0] operand,             // Operand from multiplier/shifter
	input wire logic clr_first_clip,             // Software clear of first clip flag
	input wire logic clr_second_clip,            // Software clear of second clip flag
	input wire logic [1:0] wb_mode,              // Write-back mode, dacc_wb_e
	input wire logic wb_excluded_op,             // Multiply, negated, distance ops
	input wire logic store_valid,                // Store-accumulator request
	input wire logic store_round,                // Rounded store variant
	input wire logic ptr_load,                   // Load write-back pointer
	input wire logic [15:0] ptr_load_value,      // Value for pointer load
	input wire logic shift_valid,                // Shift request
	input wire logic shift_use_xbus,             // Shift source is X bus
	input wire logic shift_arith,                // Arithmetic right shift
	input wire logic signed [5:0] shift_amount,  // Signed amount
	input wire logic [15:0] xbus_rdata,          // X bus read data
	output logic [39:0] first_accumulator,       // Accumulator A
	output logic [39:0] second_accumulator,      // Accumulator B
	output logic first_guard_ovf_flag,           // Guard overflow, first
	output logic second_guard_ovf_flag,          // Guard overflow, second
	output logic first_clip_flag,                // Sticky clip, first
	output logic second_clip_flag,               // Sticky clip, second
	output logic either_guard_ovf_flag,          // OR of guard flags
	output logic either_clip_flag,               // OR of clip flags
	output logic arith_trap,                     // Arithmetic warning trap pulse
	output logic [15:0] writeback_pointer,       // Write-back pointer register
	output logic xbus_we,                        // X bus write strobe
	output logic [15:0] xbus_waddr,              // X bus write address
	output logic [15:0] xbus_wdata,              // X bus write data
	output logic [39:0] shift_result,            // Registered shifter result
	output logic [15:0] shift_result_word        // Registered 16-bit MCU result
);
	logic [39:0] acc_r [2], acc_nxt [2];  // Accumulators
	logic [1:0] gov_r, gov_nxt;          // Guard overflow flags
	logic [1:0] clip_r, clip_nxt;        // Sticky clip flags
	logic trap_r, trap_nxt;              // Trap pulse
	logic [15:0] ptr_r, ptr_nxt;         // Write-back pointer
	logic we_r, we_nxt;                  // X bus strobe
	logic [15:0] waddr_r, waddr_nxt;     // X bus address
	logic [15:0] wdata_r, wdata_nxt;     // X bus data
	logic [39:0] sh_r, sh_nxt;           // Shift result
	logic [40:0] sum;                    // Raw adder sum with carry out
	logic [39:0] a_in, b_in, res;        // Adder inputs, result
	logic ovf39, ovf31, guard_mix;       // Overflow conditions
	logic clip_on, width32;              // Target clip mode
	logic [15:0] st_word, wb_word;       // Rounded words
	logic [39:0] sh_comb;                // Shifter output
	dacc_wb_e wb_e;                      // Typed write-back mode

	// Store of the target accumulator, truncated or rounded
	dacc_round_clip u_store (
		.acc(acc_r[target_sel]),
		.round_en(store_round),          // RULE_18
		.round_mode_select(round_mode_select),
		.store_clip_enable(store_clip_enable),
		.word_out(st_word)
	);

	// Write-back of the non-target accumulator, always rounded
	dacc_round_clip u_wb (
		.acc(acc_r[~target_sel]),        // RULE_13
		.round_en(1'b1),                 // RULE_18
		.round_mode_select(round_mode_select),
		.store_clip_enable(store_clip_enable),
		.word_out(wb_word)
	);

	// Barrel shifter on the target accumulator or X bus
	dacc_shifter #(.W(ACC_W)) u_shift (
		.acc_in(acc_r[target_sel]),      // RULE_22
		.xbus_in(xbus_rdata),
		.use_xbus(shift_use_xbus),
		.arith(shift_arith),
		.amount(shift_amount),
		.result(sh_comb)
	);

	// Adder and overflow detection
	always_comb begin
		a_in = zero_acc_in ? 40'h0000000000 : acc_r[target_sel]; // RULE_01
		b_in = subtract ? ~operand : operand;                      // RULE_01
		// Borrow input active low on subtract: carry_in=1 means no borrow
		sum = {1'b0, a_in} + {1'b0, b_in} + {40'h0000000000, carry_in};
		res = sum[39:0];
		// Signed overflow out of bit 39
		ovf39 = (a_in[39] == b_in[39]) && (res[39] != a_in[39]);
		// Guard bits not all equal RULE_02
		guard_mix = (res[GUARD_HI:GUARD_LO] != 8'h00) && (res[GUARD_HI:GUARD_LO] != 8'hFF);
		// Bit 31 overflow: value out of 1.31 range, or sign destroyed
		ovf31 = ovf39 || !(res[39:31] == 9'h000 || res[39:31] == 9'h1FF);
		clip_on = core_config_register[CFG_CLIP_EN_LO + 32'(target_sel)]; // RULE_23
		width32 = core_config_register[CFG_CLIP_WIDTH];                   // RULE_08
	end

	// Accumulator and flag next state
	always_comb begin
		acc_nxt = acc_r;
		gov_nxt = gov_r;
		clip_nxt = clip_r;
		trap_nxt = 1'b0;
		// Software clears first, so a same-cycle set wins below
		if (clr_first_clip) clip_nxt[0] = 1'b0;   // RULE_05
		if (clr_second_clip) clip_nxt[1] = 1'b0;  // RULE_05
		if (add_valid) begin
			acc_nxt[target_sel] = res;
			// Only the target's flags move RULE_24
			gov_nxt[target_sel] = guard_mix && !(clip_on && width32); // RULE_03 RULE_11
			if (clip_on && !width32 && ovf39) begin
				// Sign of true result is inverse of wrapped bit 39
				acc_nxt[target_sel] = res[39] ? MAX_POS_40 : MAX_NEG_40; // RULE_09
				clip_nxt[target_sel] = 1'b1;
			end else if (clip_on && width32 && ovf31) begin
				// True sign: a_in sign when bit 39 wrapped, else result sign
				acc_nxt[target_sel] = (ovf39 ? a_in[39] : res[39]) ? MAX_NEG_32
					: MAX_POS_32; // RULE_10
				clip_nxt[target_sel] = 1'b1;
			end else if (!clip_on && ovf39) begin
				// Wrap allowed, sign lost RULE_12
				clip_nxt[target_sel] = 1'b1; // RULE_06
				trap_nxt = wrap_trap_enable;  // RULE_06
			end
			// Trap as a guard flag comes up with its enable RULE_04
			if (gov_nxt[target_sel] && !gov_r[target_sel]) begin
				if (target_sel ? second_guard_trap_enable : first_guard_trap_enable) begin
					trap_nxt = 1'b1;
				end
			end
		end
	end

	// Write-back, stores, pointer and shifter next state
	always_comb begin
		wb_e = dacc_wb_e'(wb_mode);
		ptr_nxt = ptr_r;
		we_nxt = 1'b0;
		waddr_nxt = waddr_r;
		wdata_nxt = wdata_r;
		sh_nxt = shift_valid ? sh_comb : sh_r; // RULE_21
		if (ptr_load) ptr_nxt = ptr_load_value;
		if (store_valid) begin
			// Store uses the current pointer as address
			we_nxt = 1'b1;
			waddr_nxt = ptr_r;
			wdata_nxt = st_word; // RULE_18
		end else if (!wb_excluded_op) begin
			case (wb_e)
				DACC_WB_DIRECT: begin
					ptr_nxt = wb_word; // RULE_14
				end
				DACC_WB_INDIRECT: begin
					we_nxt = 1'b1;
					waddr_nxt = ptr_r;
					wdata_nxt = wb_word;
					ptr_nxt = ptr_r + PTR_STEP; // RULE_14
				end
				default: begin
					ptr_nxt = ptr_load ? ptr_load_value : ptr_r;
				end
			endcase
		end
	end

	// Register all state except the combined bits
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			acc_r[0] <= ACC_RESET;
			acc_r[1] <= ACC_RESET;
			gov_r <= 2'h0;
			clip_r <= 2'h0;
			trap_r <= 1'b0;
			ptr_r <= PTR_RESET;
			we_r <= 1'b0;
			waddr_r <= 16'h0000;
			wdata_r <= 16'h0000;
			sh_r <= ACC_RESET;
		end else begin
			acc_r <= acc_nxt;
			gov_r <= gov_nxt;
			clip_r <= clip_nxt;
			trap_r <= trap_nxt;
			ptr_r <= ptr_nxt;
			we_r <= we_nxt;
			waddr_r <= waddr_nxt;
			wdata_r <= wdata_nxt;
			sh_r <= sh_nxt;
		end
	end

	// Outputs straight from flip-flops; combined bits kept registered too
	logic either_gov_r, either_clip_r;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			either_gov_r <= 1'b0;
			either_clip_r <= 1'b0;
		end else begin
			either_gov_r <= |gov_nxt;   // RULE_07
			either_clip_r <= |clip_nxt; // RULE_07
		end
	end

	assign first_accumulator = acc_r[0];
	assign second_accumulator = acc_r[1];
	assign first_guard_ovf_flag = gov_r[0];
	assign second_guard_ovf_flag = gov_r[1];
	assign first_clip_flag = clip_r[0];
	assign second_clip_flag = clip_r[1];
	assign either_guard_ovf_flag = either_gov_r;
	assign either_clip_flag = either_clip_r;
	assign arith_trap = trap_r;
	assign writeback_pointer = ptr_r;
	assign xbus_we = we_r;
	assign xbus_waddr = waddr_r;
	assign xbus_wdata = wdata_r;
	assign shift_result = sh_r;
	assign shift_result_word = sh_r[31:16];
endmodule

// *** rtl/dacc_pkg.sv ***
// Package for the accumulator datapath: widths, field positions, constants.
// Assumes a single core clock domain; shared by all design files.
package dacc_pkg;
	localparam int ACC_W = 40;                           // Accumulator width
	localparam int WORD_W = 16;                          // Data word width
	localparam int CFG_CLIP_EN_LO = 6;                   // Per-acc clip enables <7:6>
	localparam int CFG_CLIP_EN_HI = 7;
	localparam int CFG_CLIP_WIDTH = 4;                   // Clip width select <4>
	localparam int GUARD_LO = 32;                        // Guard bits 32..39
	localparam int GUARD_HI = 39;
	localparam logic [39:0] MAX_POS_40 = 40'h7FFFFFFFFF; // 9.31 max positive
	localparam logic [39:0] MAX_NEG_40 = 40'h8000000000; // 9.31 max negative
	localparam logic [39:0] MAX_POS_32 = 40'h007FFFFFFF; // 1.31 max positive
	localparam logic [39:0] MAX_NEG_32 = 40'hFF80000000; // 1.31 max negative
	localparam logic [15:0] LOW_HALF = 16'h8000;         // Rounding tie value
	localparam logic [15:0] WORD_MAX = 16'h7FFF;         // 1.15 max positive
	localparam logic [15:0] WORD_MIN = 16'h8000;         // 1.15 max negative
	localparam logic [15:0] PTR_STEP = 16'h0002;         // Write-back pointer step
	localparam logic [39:0] ACC_RESET = 40'h0000000000;  // Accumulator reset value
	localparam logic [15:0] PTR_RESET = 16'h0000;        // Pointer reset value
	// Write-back destination mode
	typedef enum logic [1:0] {DACC_WB_NONE, DACC_WB_DIRECT, DACC_WB_INDIRECT} dacc_wb_e;
	// Store source: non-target or target accumulator
	typedef enum logic {DACC_SRC_OTHER, DACC_SRC_TARGET} dacc_src_e;
endpackage

// *** rtl/dacc_round_clip.sv ***
// Round and data-space write clip for one accumulator store.
// Purely combinational; the caller registers the result.
module dacc_round_clip
	import dacc_pkg::*;
(
	input wire logic [39:0] acc,         // Source accumulator
	input wire logic round_en,           // Round (else truncate)
	input wire logic round_mode_select,  // 1 convergent, 0 conventional
	input wire logic store_clip_enable,  // Clip to 1.15 range
	output logic [15:0] word_out         // Word for the X bus
);
	logic [24:0] hi;  // Sign-extended high part, acc<39:15> wide enough
	logic inc;        // Increment request
	logic [24:0] sum; // Rounded value, 25 bits keeps overflow visible

	// Rounding and write clip; accumulator itself is never touched
	always_comb begin
		hi = acc[39:15];
		inc = 1'b0;
		if (round_en) begin
			inc = acc[15]; // RULE_16
			if (round_mode_select && acc[15:0] == LOW_HALF) begin
				inc = acc[16]; // RULE_17
			end
		end
		// Truncation simply drops the low word
		sum = {hi[24], hi[24:1]} + {24'h000000, inc}; // RULE_15
		word_out = sum[15:0];
		if (store_clip_enable) begin
			// Sign of the source, bit 39, decides direction
			if (!acc[39] && sum[24:15] != 10'h000) begin
				word_out = WORD_MAX; // RULE_19
			end else if (acc[39] && sum[24:15] != 10'h3FF) begin
				word_out = WORD_MIN; // RULE_19
			end
		end
		// Clip disabled: unmodified value passes RULE_20
	end
endmodule

// *** rtl/dacc_shifter.sv ***
// 40-bit barrel shifter with signed amount, one cycle, combinational.
// Positive amount shifts right, negative left; zero passes through.
module dacc_shifter
	import dacc_pkg::*;
#(
	parameter int W = 40
) (
	input wire logic [W-1:0] acc_in,    // Accumulator source
	input wire logic [15:0] xbus_in,    // X bus source
	input wire logic use_xbus,          // Select X bus source
	input wire logic arith,             // Arithmetic right shift
	input wire logic signed [5:0] amount, // Signed amount, -16..+16
	output logic [W-1:0] result         // 40-bit result, bits 31..16 for MCU
);
	logic [W-1:0] src; // Operand after placement
	logic [4:0] mag;   // Shift magnitude
	always_comb begin
		mag = amount[5] ? 5'((~amount) + 6'sd1) : amount[4:0];
		if (use_xbus) begin
			// Right shifts see the word at 16..31, left at 0..15 RULE_22
			src = amount[5] ? {{(W-16){1'b0}}, xbus_in}
				: {{(W-32){xbus_in[15] & arith}}, xbus_in, 16'h0000};
		end else begin
			src = acc_in;
		end
		if (amount == 6'sd0) begin
			result = src; // RULE_21
		end else if (amount[5]) begin
			result = src << mag; // RULE_21
		end else if (arith) begin
			result = W'($signed(src) >>> mag);
		end else begin
			result = src >> mag;
		end
	end
endmodule

// *** dv/dacc_xbus_model.sv ***
// X bus partner: records data writes, supplies read words to the shifter.
// Assumes single-cycle write strobes sampled on the core clock.
module dacc_xbus_model (
	input wire logic mclk,              // Core clock
	input wire logic resetn,            // Active-low reset
	input wire logic xbus_we,           // Write strobe from the datapath
	input wire logic [15:0] xbus_waddr, // Write address
	input wire logic [15:0] xbus_wdata, // Write data
	input wire logic [15:0] rd_word,    // Word the bench puts on the bus
	output logic [15:0] xbus_rdata,     // Read data toward the shifter
	output logic [15:0] wr_count,       // Writes seen so far
	output logic [15:0] wr_addr,        // Last written address
	output logic [15:0] wr_data         // Last written word
);
	// Bench scrambles the word once a shift has taken it
	assign xbus_rdata = rd_word;
	// One strobe, one write; a stuck strobe shows as extra counts
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			{wr_count, wr_addr, wr_data} <= '0;
		end else if (xbus_we) begin
			wr_count <= wr_count + 16'h0001;
			wr_addr <= xbus_waddr;
			wr_data <= xbus_wdata;
		end
	end
endmodule

// *** dv/dacc_core_asserts.sv ***
// Port-level checks for the accumulator datapath.
// Assumes one core clock; bound into every dacc_core instance.
module dacc_core_asserts
	import dacc_pkg::*;
(
	input wire logic mclk,                       // Core clock
	input wire logic resetn,                     // Active-low reset
	input wire logic [15:0] core_config_register, // Clip enables and width
	input wire logic add_valid,                  // Adder pass
	input wire logic target_sel,                 // Target accumulator
	input wire logic clr_first_clip,             // Clear of first clip flag
	input wire logic [1:0] wb_mode,              // Write-back mode
	input wire logic wb_excluded_op,             // Write-back suppressed
	input wire logic store_valid,                // Store request
	input wire logic ptr_load,                   // Pointer load
	input wire logic first_guard_ovf_flag,       // Guard flag, first
	input wire logic second_guard_ovf_flag,      // Guard flag, second
	input wire logic first_clip_flag,            // Clip flag, first
	input wire logic second_clip_flag,           // Clip flag, second
	input wire logic either_guard_ovf_flag,      // Combined guard bit
	input wire logic either_clip_flag,           // Combined clip bit
	input wire logic arith_trap,                 // Trap pulse
	input wire logic [15:0] writeback_pointer,   // Write-back pointer
	input wire logic xbus_we,                    // Write strobe
	input wire logic [15:0] xbus_waddr           // Write address
);
	// Everything here lives on the core clock
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	a_guard_either: assert property (either_guard_ovf_flag == (first_guard_ovf_flag | second_guard_ovf_flag))
		else $error("combined guard bit differs from flags");
	a_clip_either: assert property (either_clip_flag == (first_clip_flag | second_clip_flag))
		else $error("combined clip bit differs from flags");
	a_clip_sticky: assert property ($fell(first_clip_flag) |-> $past(clr_first_clip))
		else $error("clip flag dropped without software clear");
	a_guard_hold: assert property (!add_valid |=> $stable({first_guard_ovf_flag, second_guard_ovf_flag}))
		else $error("guard flag moved without adder pass");
	a_other_kept: assert property (add_valid && target_sel |=> $stable(first_guard_ovf_flag))
		else $error("untargeted guard flag changed");
	a_narrow_noguard: assert property (add_valid && target_sel && core_config_register[7] && core_config_register[4] |=> !second_guard_ovf_flag)
		else $error("guard flag set in 32-bit clip mode");
	a_trap_cause: assert property (arith_trap |-> $past(add_valid))
		else $error("trap without adder pass");
	a_store_write: assert property (store_valid |=> xbus_we && xbus_waddr == $past(writeback_pointer))
		else $error("store did not write at pointer");
	a_excluded_quiet: assert property (wb_excluded_op && !store_valid |=> !xbus_we)
		else $error("excluded operation wrote back");
	a_ptr_step: assert property (add_valid && wb_mode == 2'h2 && !wb_excluded_op && !store_valid && !ptr_load |=> writeback_pointer == $past(writeback_pointer) + 16'h0002)
		else $error("pointer did not step by two");
endmodule
bind dacc_core dacc_core_asserts dacc_core_asserts_i (.mclk, .resetn, .core_config_register,
	.add_valid, .target_sel, .clr_first_clip, .wb_mode, .wb_excluded_op, .store_valid, .ptr_load,
	.first_guard_ovf_flag, .second_guard_ovf_flag, .first_clip_flag, .second_clip_flag,
	.either_guard_ovf_flag, .either_clip_flag, .arith_trap, .writeback_pointer, .xbus_we,
	.xbus_waddr);

// *** dv/dacc_core_bench.sv ***
// Self-checking bench for the accumulator datapath with its X bus partner.
// Assumes outputs register on the edge that samples each request.
module dacc_core_bench
	import dacc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk, resetn, first_guard_trap_enable, second_guard_trap_enable, wrap_trap_enable;
	logic round_mode_select, store_clip_enable, add_valid, target_sel, subtract, zero_acc_in;
	logic carry_in, clr_first_clip, clr_second_clip, wb_excluded_op, store_valid, store_round;
	logic ptr_load, shift_valid, shift_use_xbus, shift_arith, xbus_we, arith_trap;
	logic first_guard_ovf_flag, second_guard_ovf_flag, first_clip_flag, second_clip_flag;
	logic either_guard_ovf_flag, either_clip_flag;
	logic [1:0] wb_mode;
	logic signed [5:0] shift_amount;
	logic [15:0] core_config_register, ptr_load_value, xbus_rdata, writeback_pointer, rd_word;
	logic [15:0] xbus_waddr, xbus_wdata, shift_result_word, wr_count, wr_addr, wr_data;
	logic [39:0] operand, first_accumulator, second_accumulator, shift_result;
	int failures, compares, cycles;
	// Store cases: accumulator, {round, convergent, clip}, expected word
	logic [58:0] store_cases [11] = '{{40'h0012348000, 3'h0, 16'h1234},
		{40'h0012348000, 3'h4, 16'h1235}, {40'h0012348000, 3'h6, 16'h1234},
		{40'h0012358000, 3'h6, 16'h1236}, {40'h0012347FFF, 3'h4, 16'h1234},
		{40'h0012348001, 3'h6, 16'h1235}, {40'h0080000000, 3'h1, 16'h7FFF},
		{40'h0080000000, 3'h0, 16'h8000}, {40'hFF7FFFFFFF, 3'h1, 16'h8000},
		{40'hFF7FFFFFFF, 3'h0, 16'h7FFF}, {40'h007FFF8000, 3'h5, 16'h7FFF}};
	// Shift cases on bus word 0xB234: amount, expected result; odd cases arithmetic
	logic [45:0] shift_cases [4] = '{{6'h3C, 40'h00000B2340}, {6'h04, 40'hFFFB234000},
		{6'h10, 40'h000000B234}, {6'h30, 40'h00B2340000}};
	dacc_core dacc_core_i (.mclk, .resetn, .core_config_register, .first_guard_trap_enable,
		.second_guard_trap_enable, .wrap_trap_enable, .round_mode_select, .store_clip_enable,
		.add_valid, .target_sel, .subtract, .zero_acc_in, .carry_in, .operand, .clr_first_clip,
		.clr_second_clip, .wb_mode, .wb_excluded_op, .store_valid, .store_round, .ptr_load,
		.ptr_load_value, .shift_valid, .shift_use_xbus, .shift_arith, .shift_amount,
		.xbus_rdata, .first_accumulator, .second_accumulator, .first_guard_ovf_flag,
		.second_guard_ovf_flag, .first_clip_flag, .second_clip_flag, .either_guard_ovf_flag,
		.either_clip_flag, .arith_trap, .writeback_pointer, .xbus_we, .xbus_waddr, .xbus_wdata,
		.shift_result, .shift_result_word);
	dacc_xbus_model dacc_xbus_model_i (.mclk, .resetn, .xbus_we, .xbus_waddr, .xbus_wdata,
		.rd_word, .xbus_rdata, .wr_count, .wr_addr, .wr_data);
	// 20 MHz core clock
	always #25 mclk = ~mclk;
	// Hang guard, far above the roughly 130 cycles needed
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			complete_run();
		end
	end
	// Verdict and end of run
	task automatic complete_run();
		if (failures == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Value compare, four-state exact
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One adder pass; sampled on the second edge, checked just after
	task automatic add(input logic tgt, sub, zero, cin, input logic [39:0] op,
			input logic [1:0] wb = 2'h0);
		@(posedge mclk);
		{add_valid, target_sel, subtract, zero_acc_in, carry_in, operand, wb_mode} <=
				{1'h1, tgt, sub, zero, cin, op, wb};
		@(posedge mclk);
		{add_valid, wb_mode} <= 3'h0;
		#1;
	endtask
	// Software clear of clip flags
	task automatic clr(input logic [1:0] which);
		@(posedge mclk);
		{clr_second_clip, clr_first_clip} <= which;
		@(posedge mclk);
		{clr_second_clip, clr_first_clip} <= 2'h0;
		#1;
	endtask
	// Store of the target accumulator; strobe stands one cycle
	task automatic store(input logic [2:0] mode, input logic [15:0] exp);
		@(posedge mclk);
		{store_valid, store_round, round_mode_select, store_clip_enable} <= {1'h1, mode};
		@(posedge mclk);
		store_valid <= 1'h0;
		#1;
		chk({xbus_we, xbus_waddr, xbus_wdata}, {1'h1, writeback_pointer, exp});
	endtask
	// Guard flag, carry and borrow, trap enable, untargeted side
	task automatic t_guard();
		@(posedge mclk);
		first_guard_trap_enable <= 1'h1;
		add(0, 0, 1, 0, 40'h0100000000);
		chk({first_guard_ovf_flag, either_guard_ovf_flag, second_guard_ovf_flag}, 3'h6);
		chk(arith_trap, 1'h1);
		add(0, 1, 0, 1, 40'h0100000000);
		chk({first_accumulator, first_guard_ovf_flag, either_guard_ovf_flag}, 42'h0);
		add(0, 1, 0, 0, 40'h1);
		chk(first_accumulator, 40'hFFFFFFFFFE);
		add(1, 0, 1, 0, 40'hFE00000000);
		chk({second_guard_ovf_flag, first_guard_ovf_flag, arith_trap}, 3'h4);
		add(1, 0, 1, 0, MAX_NEG_32);
		chk(second_guard_ovf_flag, 1'h0);
	endtask
	// No clipping: wrap, sticky flag, trap, software clear
	task automatic t_wrap();
		@(posedge mclk);
		{first_guard_trap_enable, wrap_trap_enable} <= 2'h1;
		add(0, 0, 1, 0, MAX_POS_40);
		add(0, 0, 0, 1, 40'h0);
		chk(first_accumulator, MAX_NEG_40);
		chk({first_clip_flag, either_clip_flag, arith_trap}, 3'h7);
		add(0, 0, 0, 0, 40'h0);
		chk(first_clip_flag, 1'h1);
		clr(2'h1);
		chk({first_clip_flag, either_clip_flag}, 2'h0);
	endtask
	// 40-bit clipping on the first side only
	task automatic t_sat40();
		@(posedge mclk);
		core_config_register <= 16'h0040;
		add(0, 0, 1, 0, MAX_POS_40);
		add(0, 0, 0, 1, 40'h0);
		chk({first_accumulator, first_clip_flag, arith_trap}, {MAX_POS_40, 2'h2});
		add(0, 0, 1, 0, MAX_NEG_40);
		add(0, 1, 0, 1, 40'h1);
		chk(first_accumulator, MAX_NEG_40);
		add(1, 0, 1, 0, MAX_POS_40);
		add(1, 0, 0, 1, 40'h0);
		chk({second_accumulator, second_clip_flag}, {MAX_NEG_40, 1'h1});
	endtask
	// 32-bit clipping on the second side, guard flag held low
	task automatic t_sat32();
		@(posedge mclk);
		core_config_register <= 16'h0090;
		clr(2'h3);
		add(0, 0, 1, 0, 40'h0); // Drop the first guard flag left from earlier
		add(1, 0, 1, 0, MAX_POS_32);
		add(1, 0, 0, 1, 40'h0);
		chk({second_accumulator, second_clip_flag, second_guard_ovf_flag}, {MAX_POS_32, 2'h2});
		add(1, 0, 1, 0, MAX_NEG_32);
		add(1, 1, 0, 1, 40'h1);
		chk({second_accumulator, second_clip_flag}, {MAX_NEG_32, 1'h1});
		add(1, 0, 1, 0, 40'h0100000000);
		chk({second_guard_ovf_flag, either_guard_ovf_flag}, 2'h0);
	endtask
	// Stores: truncate, both roundings, write clip, source untouched
	task automatic t_store();
		@(posedge mclk);
		core_config_register <= 16'h0000;
		foreach (store_cases[i]) begin
			add(0, 0, 1, 0, store_cases[i][58:19]);
			store(store_cases[i][18:16], store_cases[i][15:0]);
			chk(first_accumulator, store_cases[i][58:19]);
		end
	endtask
	// Write-back: indirect with step, excluded op, direct load
	task automatic t_wb();
		@(posedge mclk);
		{ptr_load, ptr_load_value, round_mode_select} <= {1'h1, 16'h0100, 1'h0};
		@(posedge mclk);
		ptr_load <= 1'h0;
		add(1, 0, 1, 0, 40'h0012348000);
		add(0, 0, 1, 0, 40'h5, 2'h2);
		chk({xbus_we, xbus_waddr, xbus_wdata, writeback_pointer}, 49'h1_0100_1235_0102);
		@(posedge mclk);
		wb_excluded_op <= 1'h1;
		add(0, 0, 1, 0, 40'h5, 2'h2);
		chk({xbus_we, writeback_pointer, wr_count, wr_data}, 49'h0_0102_000C_1235);
		@(posedge mclk);
		wb_excluded_op <= 1'h0;
		add(0, 0, 1, 0, 40'h5, 2'h1);
		chk(writeback_pointer, 16'h1235);
	endtask
	// Bus word shifts both ways, sign fill, and the largest amounts
	task automatic t_shift();
		foreach (shift_cases[i]) begin
			@(posedge mclk);
			{shift_valid, shift_use_xbus, shift_arith, shift_amount, rd_word} <=
					{2'h3, i[0], shift_cases[i][45:40], 16'hB234};
			@(posedge mclk);
			{shift_valid, rd_word} <= {1'h0, 16'hEDCB};
			#1;
			chk({shift_result_word, shift_result}, {shift_cases[i][31:16], shift_cases[i][39:0]});
		end
	endtask
	// Reset, then scenarios in order
	initial begin
		{mclk, resetn, core_config_register, first_guard_trap_enable, second_guard_trap_enable,
			wrap_trap_enable, round_mode_select, store_clip_enable, add_valid, target_sel,
			subtract, zero_acc_in, carry_in, operand, clr_first_clip, clr_second_clip, wb_mode,
			wb_excluded_op, store_valid, store_round, ptr_load, ptr_load_value, shift_valid,
			shift_use_xbus, shift_arith, shift_amount, rd_word} = '0;
		repeat (20) @(posedge mclk);
		resetn <= 1'h1;
		#1;
		chk({first_accumulator, writeback_pointer, xbus_we, arith_trap, either_clip_flag}, 59'h0);
		t_guard();
		t_wrap();
		t_sat40();
		t_sat32();
		t_store();
		t_wb();
		t_shift();
		complete_run();
	end
endmodule
